// *** verilog/gdc_host_ctrl.sv ***
// host side controller driving the isolated gate driver pins
// Behaviour
// [RULE_01] fault and ready flags are open-drain; fault is low active, ready is high active
// [RULE_02] reset/enable floats low: driver off by default
// [RULE_03] controller drives reset/enable high to enable
// [RULE_04] reset/enable low keeps gate off always
// [RULE_05] fault latches gate and flag low until reset
// [RULE_06] clear pulse only after fault mute interval
// [RULE_07] auto reset: tie noninverting pwm to reset/enable
// [RULE_08] auto reset inverting: invert pwm into reset/enable
// [RULE_09] driver accepts reset every switching cycle
// [RULE_10] clamp holds gate low below threshold
// [RULE_11] clamp output driven when pullup below threshold
// [RULE_12] clamp path delay must exceed deadtime
// [RULE_13] both pwm inputs high forces gate low
// [RULE_14] pulses under 40 ns are ignored
// [RULE_15] undervoltage pulls gate low, ready flag drops
// [RULE_16] fault flag latched low until reset
// [RULE_17] gate high only noninv high, inv low
// [RULE_18] clamp released while gate commanded high
`timescale 1ns/1ps
`default_nettype none
`include "gdc_map.svh"
module gdc_host_ctrl
	import gdc_pkg::*;
(
	// clock and reset
	input wire logic mclk_in,
	input wire logic srst_in,
	// user commands
	input wire logic enable_in,
	input wire logic pwm_in,
	input wire logic pwm_b_in,
	input wire logic [1:0] mode_in,
	input wire logic clear_req_in,
	// driver flags (open-drain lines, already resolved)
	input wire logic fault_flag_n_in,
	input wire logic ready_in,
	// driver input pins
	output logic drv_pwm_pos_out,
	output logic drv_pwm_neg_out,
	output logic drv_rst_en_out,
	// user status
	output logic fault_out,
	output logic supply_ok_out,
	output logic clear_busy_out,
	output logic clear_done_out
);
	////////////////////////////////////////////////////////////////////
	gdc_state_t st_q, st_d;
	logic pos_q, neg_q, rsten_q, rsten_d;
	logic fault_q, rdy_q, done_q;
	logic timer_load;
	logic [`GDC_CNT_W-1:0] timer_cnt;
	logic timer_done;
	wire fault_seen = ~fault_flag_n_in; // [RULE_16]
	wire auto_mode = (mode_in != `GDC_MODE_MANUAL);
	// auto modes derive reset/enable from pwm, so no timed clear is needed
	wire auto_level = (mode_in == `GDC_MODE_AUTO_INV) ? ~pwm_b_in
		: pwm_in; // [RULE_07] [RULE_08]
	wire start_mute = (st_q == GDC_RUN) && fault_seen && !auto_mode;
	wire start_clr = (st_q == GDC_MUTE) && timer_done && clear_req_in;
	assign timer_load = start_mute || start_clr;
	assign timer_cnt = start_mute ? `GDC_CNT_W'(`GDC_MUTE_CYCLES)
		: `GDC_CNT_W'(`GDC_RST_PULSE_CYCLES); // [RULE_06] [RULE_14]
	gdc_pulse_timer u_timer (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.load_in(timer_load),
		.count_in(timer_cnt),
		.done_out(timer_done)
	);
	////////////////////////////////////////////////////////////////////
	always_comb begin
		st_d = st_q;
		rsten_d = 1'b0;
		case (st_q)
			GDC_OFF: begin
				if (enable_in) begin
					st_d = GDC_RUN;
				end
			end
			GDC_RUN: begin
				rsten_d = auto_mode ? auto_level : 1'b1; // [RULE_03] [RULE_09]
				if (!enable_in) begin
					// drop at once so the pin is never high while off [RULE_04]
					st_d = GDC_OFF;
					rsten_d = 1'b0;
				end else if (start_mute) begin
					st_d = GDC_MUTE;
					rsten_d = 1'b1;
				end
			end
			GDC_MUTE: begin
				rsten_d = 1'b1; // held high until a clear request after the mute time [RULE_06]
				if (!enable_in) begin
					st_d = GDC_OFF;
					rsten_d = 1'b0;
				end else if (start_clr) begin
					st_d = GDC_CLEAR;
					rsten_d = 1'b0;
				end
			end
			GDC_CLEAR: begin
				rsten_d = 1'b0; // low pulse longer than deglitch [RULE_14]
				if (timer_done) begin
					st_d = enable_in ? GDC_RUN : GDC_OFF;
					rsten_d = enable_in;
				end
			end
			default: begin
				st_d = GDC_OFF;
			end
		endcase
	end
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			st_q <= GDC_OFF;
			rsten_q <= 1'b0; // [RULE_02]
			pos_q <= 1'b0;
			neg_q <= 1'b0;
			fault_q <= 1'b0;
			rdy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			st_q <= st_d;
			rsten_q <= rsten_d;
			// no gate request while off, muted or clearing [RULE_04] [RULE_05]
			pos_q <= pwm_in && (st_d == GDC_RUN);
			neg_q <= pwm_b_in;
			fault_q <= fault_seen; // [RULE_01] [RULE_16]
			rdy_q <= ready_in; // [RULE_15]
			done_q <= (st_q == GDC_CLEAR) && timer_done;
		end
	end
	assign drv_pwm_pos_out = pos_q; // [RULE_17]
	assign drv_pwm_neg_out = neg_q; // [RULE_13]
	assign drv_rst_en_out = rsten_q;
	assign fault_out = fault_q;
	assign supply_ok_out = rdy_q;
	assign clear_busy_out = (st_q == GDC_MUTE) || (st_q == GDC_CLEAR);
	assign clear_done_out = done_q;
	////////////////////////////////////////////////////////////////////
	// checks
	a_off_low: assert property (@(posedge mclk_in) disable iff (srst_in)
		(st_q == GDC_OFF) |-> !drv_rst_en_out) // [RULE_02]
		else $error("reset/enable high while off");
	a_off_gate: assert property (@(posedge mclk_in) disable iff (srst_in)
		(st_q == GDC_OFF) |=> !drv_pwm_pos_out || st_q == GDC_RUN) // [RULE_04]
		else $error("gate request while off");
	a_mute_hold: assert property (@(posedge mclk_in) disable iff (srst_in)
		(st_q == GDC_MUTE) && !timer_done |-> drv_rst_en_out) // [RULE_06]
		else $error("clear pulse inside mute time");
	a_clear_len: assert property (@(posedge mclk_in) disable iff (srst_in)
		$rose(st_q == GDC_CLEAR) |-> !drv_rst_en_out [*8]) // [RULE_14]
		else $error("clear pulse too short");
	a_fault_seen: assert property (@(posedge mclk_in) disable iff (srst_in)
		!fault_flag_n_in |=> fault_out) // [RULE_16]
		else $error("fault not reported");
	a_ready_seen: assert property (@(posedge mclk_in) disable iff (srst_in)
		ready_in |=> supply_ok_out) // [RULE_15]
		else $error("ready not reported");
	a_auto_follow: assert property (@(posedge mclk_in) disable iff (srst_in)
		(st_q == GDC_RUN) && enable_in && mode_in == `GDC_MODE_AUTO_NONINV
		|=> drv_rst_en_out == $past(pwm_in)) // [RULE_07]
		else $error("auto reset not following pwm");
	a_auto_inv: assert property (@(posedge mclk_in) disable iff (srst_in)
		(st_q == GDC_RUN) && enable_in && mode_in == `GDC_MODE_AUTO_INV
		|=> drv_rst_en_out == !$past(pwm_b_in)) // [RULE_08]
		else $error("auto reset not inverting pwm");
	c_enable: cover property (@(posedge mclk_in) st_q == GDC_RUN);
	c_mute: cover property (@(posedge mclk_in) st_q == GDC_MUTE);
	c_clear: cover property (@(posedge mclk_in) clear_done_out);
endmodule : gdc_host_ctrl
`default_nettype wire

// *** inc/gdc_map.svh ***
// timing and field constants for the gate driver host controller
`ifndef GDC_MAP_SVH
`define GDC_MAP_SVH
`define GDC_CLK_PERIOD_PS 4000
`define GDC_MUTE_TIME_NS 20000
`define GDC_MUTE_CYCLES ((`GDC_MUTE_TIME_NS * 1000) / `GDC_CLK_PERIOD_PS)
`define GDC_DEGLITCH_NS 40
`define GDC_DEGLITCH_CYCLES \
	(((`GDC_DEGLITCH_NS * 1000) + `GDC_CLK_PERIOD_PS - 1) / `GDC_CLK_PERIOD_PS)
`define GDC_RST_PULSE_CYCLES (2 * `GDC_DEGLITCH_CYCLES)
`define GDC_CNT_W 16
`define GDC_MODE_MANUAL 2'h0
`define GDC_MODE_AUTO_NONINV 2'h1
`define GDC_MODE_AUTO_INV 2'h2
`endif

// *** inc/gdc_pkg.sv ***
// types for the gate driver host controller
package gdc_pkg;
	typedef enum logic [3:0] {
		GDC_OFF = 4'h1,
		GDC_RUN = 4'h2,
		GDC_MUTE = 4'h4,
		GDC_CLEAR = 4'h8
	} gdc_state_t;
	typedef logic [1:0] gdc_mode_t;
endpackage : gdc_pkg

// *** verilog/gdc_pulse_timer.sv ***
// down counter: loads a count, flags done when it reaches zero
`timescale 1ns/1ps
`default_nettype none
`include "gdc_map.svh"
module gdc_pulse_timer (
	// clock and reset
	input wire logic mclk_in,
	input wire logic srst_in,
	// control
	input wire logic load_in,
	input wire logic [`GDC_CNT_W-1:0] count_in,
	// status
	output logic done_out
);
	logic [`GDC_CNT_W-1:0] cnt_q;
	always_ff @(posedge mclk_in) begin
		if (srst_in || load_in) begin
			cnt_q <= srst_in ? '0 : count_in;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end
	assign done_out = (cnt_q == '0);
endmodule : gdc_pulse_timer
`default_nettype wire

// *** sim/gdc_drv_model.sv ***
// behavioural isolated gate driver seen from the host pins
`timescale 1ns/1ps
`default_nettype none
module gdc_drv_model (
	// host pins
	input wire logic mclk_in,
	input wire logic pos_in,
	input wire logic neg_in,
	input wire logic rst_en_in,
	// scenario controls
	input wire logic trip_in,
	input wire logic supply_in,
	// driver outputs
	output logic flt_n_out,
	output logic rdy_out,
	output logic gate_out
);
	logic flt_q = 1'b0;
	int low_q = 0;
	// a floating pin reads as low through the pulldown
	wire en_w = (rst_en_in === 1'b1);
	always @(posedge mclk_in) begin
		low_q <= en_w ? 0 : low_q + 1;
		if (trip_in && en_w) begin
			flt_q <= 1'b1;
		end else if (low_q >= 10) begin
			flt_q <= 1'b0;
		end
	end
	// open drain stand-in: drives low on fault and drives the high itself in place of the pull-up
	assign flt_n_out = flt_q ? 1'b0 : 1'b1;
	assign rdy_out = supply_in;
	assign gate_out = en_w && supply_in && !flt_q
		&& pos_in && !neg_in;
	// clamp drive: on while gate is low, released when gate is driven high
	wire clamp_w = !gate_out;
endmodule : gdc_drv_model
`default_nettype wire

// *** sim/gdc_host_ctrl_bench.sv ***
// self-checking bench for the gate driver host controller
`timescale 1ns/1ps
`default_nettype none
module gdc_host_ctrl_bench;
	logic mclk_in = 1'b0;
	logic srst_in = 1'b1;
	logic enable_in = 1'b0, pwm_in = 1'b0, pwm_b_in = 1'b0;
	logic clear_req_in = 1'b0, trip = 1'b0, supply = 1'b1;
	logic [1:0] mode_in = 2'h0;
	logic [11:0] n;
	logic [11:0] q[$];
	wire flt_n, rdy, gate, pos, neg, rst_en, fault, sok, busy, done;
	wire [5:0] got = {pos, neg, rst_en, fault, sok, busy};
	int err_count = 0, compares = 0, cycles = 0, seed = 28;
	always #2 mclk_in = ~mclk_in;
	gdc_host_ctrl dut (.mclk_in(mclk_in), .srst_in(srst_in),
		.enable_in(enable_in), .pwm_in(pwm_in), .pwm_b_in(pwm_b_in),
		.mode_in(mode_in), .clear_req_in(clear_req_in),
		.fault_flag_n_in(flt_n), .ready_in(rdy), .drv_pwm_pos_out(pos),
		.drv_pwm_neg_out(neg), .drv_rst_en_out(rst_en), .fault_out(fault),
		.supply_ok_out(sok), .clear_busy_out(busy), .clear_done_out(done));
	gdc_drv_model drv (.mclk_in(mclk_in), .pos_in(pos), .neg_in(neg),
		.rst_en_in(rst_en), .trip_in(trip), .supply_in(supply),
		.flt_n_out(flt_n), .rdy_out(rdy), .gate_out(gate));
	task automatic end_of_test;
		if (err_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	// note the expectation for the edge that follows, then move on
	task automatic step(input logic [5:0] e, input logic [5:0] m);
		q.push_back({m, e});
		@(negedge mclk_in);
	endtask : step
	////////////////////////////////////////////////////////////////////
	// watcher: one result per edge while notes are queued
	always @(posedge mclk_in) begin
		cycles <= cycles + 1;
		if (cycles > 20000) begin
			err_count++;
			end_of_test();
		end
		#1;
		if (q.size() > 0) begin
			n = q.pop_front();
			compares++;
			if ((got & n[11:6]) !== (n[5:0] & n[11:6])) begin
				err_count++;
				$display("Error %0t got %h exp %h", $time, got, n[5:0]);
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(negedge mclk_in);
		srst_in = 1'b0;
		step(6'h02, 6'h3F);
		enable_in = 1'b1;
		step(6'h00, 6'h08);
		step(6'h08, 6'h08);
		repeat (200) begin
			pwm_in = $random(seed);
			pwm_b_in = $random(seed);
			step({pwm_in, pwm_b_in, 4'hA}, 6'h3F);
		end
		for (int k = 1; k < 3; k++) begin
			mode_in = 2'(k);
			repeat (50) begin
				pwm_in = $random(seed);
				pwm_b_in = $random(seed);
				step({pwm_in, pwm_b_in, (k == 1) ? pwm_in : !pwm_b_in,
					3'h2}, 6'h3F);
			end
		end
		// manual clear: early requests must be refused
		mode_in = 2'h0;
		// let reset/enable settle high before the trip is seen
		step(6'h0A, 6'h0F);
		trip = 1'b1;
		step(6'h00, 6'h00);
		trip = 1'b0;
		clear_req_in = 1'b1;
		repeat (100) step(6'h0F, 6'h0F);
		clear_req_in = 1'b0;
		repeat (5000) @(negedge mclk_in);
		clear_req_in = 1'b1;
		step(6'h00, 6'h00);
		clear_req_in = 1'b0;
		repeat (20) step(6'h00, 6'h08);
		@(posedge mclk_in);
		#1;
		compares++;
		if (done !== 1'b1) begin
			err_count++;
			$display("Error %0t got %h exp %h", $time, done, 1'b1);
		end
		@(negedge mclk_in);
		step(6'h00, 6'h00);
		step(6'h0A, 6'h0F);
		supply = 1'b0;
		step(6'h00, 6'h00);
		step(6'h08, 6'h0A);
		supply = 1'b1;
		step(6'h00, 6'h00);
		step(6'h0A, 6'h0A);
		enable_in = 1'b0;
		step(6'h00, 6'h00);
		step(6'h00, 6'h08);
		end_of_test();
	end
endmodule : gdc_host_ctrl_bench
`default_nettype wire
